//--- rtl/fcr_pkg.sv
// Purpose: Shared constants and types for the flow control enable resolver
// Assumes: Three switch ports, port 0 faces the virtual PHY
// Notes:   Pause counter counts slot quanta supplied by the MAC

package fcr_pkg;

	// ---------------------------------------------------------------
	// Port layout
	// ---------------------------------------------------------------
	localparam int FCR_NUM_PORTS = 3;
	localparam int FCR_VPHY_PORT = 0;
	localparam int FCR_PHY1_PORT = 1;
	localparam int FCR_PHY2_PORT = 2;

	// ---------------------------------------------------------------
	// Widths and reset values
	// ---------------------------------------------------------------
	localparam int          FCR_QUANTA_W   = 16;
	localparam logic [15:0] FCR_QUANTA_RST = 16'h0000;
	localparam logic [15:0] FCR_QUANTA_ONE = 16'h0001;
	localparam logic        FCR_EN_RST     = 1'b0;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	// Manual flow control settings of one port
	typedef struct packed {
		logic flow_ctrl_override;
		logic backpressure_enable;
		logic manual_tx_pause_enable;
		logic manual_rx_pause_enable;
	} fcr_manual_t;

	// Duplex and negotiation state of one port
	typedef struct packed {
		logic an_enable;
		logic an_complete;
		logic partner_an_able;
		logic full_duplex;
	} fcr_link_t;

	// Pause and asymmetric pause ability bits
	typedef struct packed {
		logic pause;
		logic asym_pause;
	} fcr_pause_adv_t;

	// The two resolved enables
	typedef struct packed {
		logic rx_en;
		logic tx_en;
	} fcr_fc_en_t;

endpackage

//--- rtl/fcr_port_resolve.sv
// Purpose: Combinational flow control enable resolution for one port
// Assumes: Local and partner bits already mapped for the port type
// Notes:   Result is registered by the caller

`timescale 1ns/1ps

module fcr_port_resolve (
	// Settings and link state
	input  fcr_pkg::fcr_manual_t    man_in,
	input  fcr_pkg::fcr_link_t      link_in,
	// Negotiated ability bits
	input  fcr_pkg::fcr_pause_adv_t local_in,
	input  fcr_pkg::fcr_pause_adv_t partner_in,
	// Resolved enables
	output fcr_pkg::fcr_fc_en_t     en_out
);
	import fcr_pkg::*;

	logic negotiating;
	logic auto_mode;
	logic half_mode;

	// Mode decode
	always_comb begin
		auto_mode   = link_in.an_enable && !man_in.flow_ctrl_override;
		negotiating = auto_mode && !link_in.an_complete;
		// Parallel detect forces half duplex
		half_mode   = !link_in.full_duplex ||
			(auto_mode && !link_in.partner_an_able);
	end

	// Enable resolution in priority order
	always_comb begin
		en_out = '0;
		if (negotiating) begin
			en_out = '0;
		end else if (half_mode) begin
			en_out.tx_en = man_in.backpressure_enable;
			en_out.rx_en = 1'b0;
		end else if (!auto_mode) begin
			en_out.tx_en = man_in.manual_tx_pause_enable;
			en_out.rx_en = man_in.manual_rx_pause_enable;
		end else begin
			if (local_in.pause && partner_in.pause) begin
				en_out = '{rx_en: 1'b1, tx_en: 1'b1};
			end else if (!local_in.pause && local_in.asym_pause &&
				partner_in.pause && partner_in.asym_pause) begin
				en_out = '{rx_en: 1'b0, tx_en: 1'b1};
			end else if (local_in.pause && local_in.asym_pause &&
				!partner_in.pause && partner_in.asym_pause) begin
				en_out = '{rx_en: 1'b1, tx_en: 1'b0};
			end else begin
				en_out = '0;
			end
		end
	end

endmodule

//--- rtl/fcr_flow_ctrl_resolver.sv
// Purpose: Flow control enables and pause gating for three switch ports
// Assumes: All inputs come from logic on the switch clock
// Notes:   Advertisement inputs are only read, never written back
//
// Function
// - Each port gets separate transmit and receive enables
// - Transmit enable permits back pressure or pause
// - Receive enable decides if pause stops transmit
// - Half duplex transmit enable follows back pressure
// - Half duplex receive enable is always zero
// - Manual or no negotiation uses manual bits
// - Negotiated full duplex resolves from ability bits
// - Negotiation in progress forces both enables low
// - Parallel detect gives half duplex behaviour
// - Both pause bits set enables both
// - Asymmetric toward partner enables transmit only
// - Asymmetric from partner enables receive only
// - Any other combination disables both
// - Manual bits never alter advertisement bits
// - Internal PHY ports use own register bits
// - Virtual PHY port swaps local and partner
// - Accepted pause frame loads counter, holds transmit

`timescale 1ns/1ps

module fcr_flow_ctrl_resolver (
	// Clock and reset
	input  logic                        clk_sys_in,
	input  logic                        rst_n_in,
	// Manual flow control settings per port
	input  fcr_pkg::fcr_manual_t        port0_external_manual_flow_ctrl_in,
	input  fcr_pkg::fcr_manual_t        port1_manual_flow_ctrl_in,
	input  fcr_pkg::fcr_manual_t        port2_manual_flow_ctrl_in,
	// Duplex and negotiation state per port
	input  fcr_pkg::fcr_link_t [2:0]    link_state_in,
	// Advertisement and partner ability bits
	input  fcr_pkg::fcr_pause_adv_t     port1_phy_negotiation_advert_in,
	input  fcr_pkg::fcr_pause_adv_t     port1_phy_partner_ability_in,
	input  fcr_pkg::fcr_pause_adv_t     port2_phy_negotiation_advert_in,
	input  fcr_pkg::fcr_pause_adv_t     port2_phy_partner_ability_in,
	input  fcr_pkg::fcr_pause_adv_t     virtual_phy_negotiation_advert_in,
	input  fcr_pkg::fcr_pause_adv_t     virtual_phy_partner_ability_in,
	// MAC pause frame and timing events
	input  logic [2:0]                  pause_frame_valid_in,
	input  logic [2:0][15:0]            pause_quanta_in,
	input  logic [2:0]                  slot_tick_in,
	input  logic [2:0]                  mac_tx_busy_in,
	// MAC flow control requests
	input  logic [2:0]                  bp_request_in,
	input  logic [2:0]                  pause_request_in,
	// Resolved enables
	output logic [2:0]                  tx_flow_ctrl_en_out,
	output logic [2:0]                  rx_flow_ctrl_en_out,
	// Gated flow control actions
	output logic [2:0]                  backpressure_assert_out,
	output logic [2:0]                  pause_send_out,
	output logic [2:0]                  tx_xoff_out,
	output logic [2:0][15:0]            pause_count_out
);
	import fcr_pkg::*;

	// ---------------------------------------------------------------
	// Input mapping
	// ---------------------------------------------------------------
	fcr_manual_t    [2:0] man;
	fcr_pause_adv_t [2:0] local_bits;
	fcr_pause_adv_t [2:0] partner_bits;
	fcr_fc_en_t     [2:0] resolved;

	// Per port source selection; advertisement bits are only read
	always_comb begin
		man[FCR_VPHY_PORT] = port0_external_manual_flow_ctrl_in;
		man[FCR_PHY1_PORT] = port1_manual_flow_ctrl_in;
		man[FCR_PHY2_PORT] = port2_manual_flow_ctrl_in;
		local_bits[FCR_PHY1_PORT]   = port1_phy_negotiation_advert_in;
		partner_bits[FCR_PHY1_PORT] = port1_phy_partner_ability_in;
		local_bits[FCR_PHY2_PORT]   = port2_phy_negotiation_advert_in;
		partner_bits[FCR_PHY2_PORT] = port2_phy_partner_ability_in;
		local_bits[FCR_VPHY_PORT]   = virtual_phy_partner_ability_in;
		partner_bits[FCR_VPHY_PORT] = virtual_phy_negotiation_advert_in;
	end

	// ---------------------------------------------------------------
	// Per port resolution
	// ---------------------------------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < FCR_NUM_PORTS; gp++) begin : g_res
			fcr_port_resolve u_res (
				.man_in     (man[gp]),
				.link_in    (link_state_in[gp]),
				.local_in   (local_bits[gp]),
				.partner_in (partner_bits[gp]),
				.en_out     (resolved[gp])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Enable registers
	// ---------------------------------------------------------------
	logic [2:0] tx_en_reg;
	logic [2:0] tx_en_next;
	logic [2:0] rx_en_reg;
	logic [2:0] rx_en_next;

	// Next enables from the resolvers
	always_comb begin
		for (int p = 0; p < FCR_NUM_PORTS; p++) begin
			tx_en_next[p] = resolved[p].tx_en;
			rx_en_next[p] = resolved[p].rx_en;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			tx_en_reg <= {3{FCR_EN_RST}};
			rx_en_reg <= {3{FCR_EN_RST}};
		end else begin
			tx_en_reg <= tx_en_next;
			rx_en_reg <= rx_en_next;
		end
	end

	assign tx_flow_ctrl_en_out = tx_en_reg;
	assign rx_flow_ctrl_en_out = rx_en_reg;

	// ---------------------------------------------------------------
	// Transmit flow control gating
	// ---------------------------------------------------------------
	// Back pressure or pause
	always_comb begin
		for (int p = 0; p < FCR_NUM_PORTS; p++) begin
			backpressure_assert_out[p] = tx_en_reg[p] &&
				!link_state_in[p].full_duplex && bp_request_in[p];
			pause_send_out[p] = tx_en_reg[p] &&
				link_state_in[p].full_duplex && pause_request_in[p];
		end
	end

	// ---------------------------------------------------------------
	// Pause counters
	// ---------------------------------------------------------------
	logic [2:0][15:0] cnt_reg;
	logic [2:0][15:0] cnt_next;

	// Load on accepted frame, count down between transmissions
	always_comb begin
		for (int p = 0; p < FCR_NUM_PORTS; p++) begin
			cnt_next[p] = cnt_reg[p];
			if (pause_frame_valid_in[p] && rx_en_reg[p]) begin
				cnt_next[p] = pause_quanta_in[p];
			end else if (!rx_en_reg[p]) begin
				cnt_next[p] = FCR_QUANTA_RST;
			end else if (slot_tick_in[p] && !mac_tx_busy_in[p] &&
				cnt_reg[p] != FCR_QUANTA_RST) begin
				cnt_next[p] = cnt_reg[p] - FCR_QUANTA_ONE;
			end
		end
	end

	// Counter registers
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	always_comb begin
		for (int p = 0; p < FCR_NUM_PORTS; p++) begin
			tx_xoff_out[p] = (cnt_reg[p] != FCR_QUANTA_RST);
		end
	end

	assign pause_count_out = cnt_reg;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	generate
		for (gp = 0; gp < FCR_NUM_PORTS; gp++) begin : g_chk
			logic busy;
			logic neg_full;
			fcr_pause_adv_t lb;
			fcr_pause_adv_t pb;
			assign busy = !man[gp].flow_ctrl_override &&
				link_state_in[gp].an_enable &&
				!link_state_in[gp].an_complete;
			assign neg_full = !man[gp].flow_ctrl_override &&
				link_state_in[gp].an_enable &&
				link_state_in[gp].an_complete &&
				link_state_in[gp].partner_an_able &&
				link_state_in[gp].full_duplex;
			assign lb = local_bits[gp];
			assign pb = partner_bits[gp];

			property p_reset_clear;
				$past(!rst_n_in) |-> !tx_en_reg[gp] && !rx_en_reg[gp];
			endproperty
			a_reset_clear: assert property (p_reset_clear)
				else $error("Enables not cleared after reset");

			property p_half_rx;
				$past(!link_state_in[gp].full_duplex) |-> !rx_en_reg[gp];
			endproperty
			a_half_rx: assert property (p_half_rx)
				else $error("Receive enable set in half duplex");

			property p_half_tx;
				$past(rst_n_in && !link_state_in[gp].full_duplex && !busy)
				|-> tx_en_reg[gp] == $past(man[gp].backpressure_enable);
			endproperty
			a_half_tx: assert property (p_half_tx)
				else $error("Half duplex tx enable not back pressure");

			property p_manual;
				$past(rst_n_in && link_state_in[gp].full_duplex &&
					(man[gp].flow_ctrl_override ||
					!link_state_in[gp].an_enable))
				|-> rx_en_reg[gp] == $past(man[gp].manual_rx_pause_enable)
				&& tx_en_reg[gp] == $past(man[gp].manual_tx_pause_enable);
			endproperty
			a_manual: assert property (p_manual)
				else $error("Manual enables not followed");

			property p_busy;
				busy |=> !rx_en_reg[gp] && !tx_en_reg[gp];
			endproperty
			a_busy: assert property (p_busy)
				else $error("Enables set during negotiation");

			property p_pardet;
				$past(busy) == 1'b0 && $past(rst_n_in &&
					!man[gp].flow_ctrl_override &&
					link_state_in[gp].an_enable &&
					!link_state_in[gp].partner_an_able)
				|-> !rx_en_reg[gp] &&
				tx_en_reg[gp] == $past(man[gp].backpressure_enable);
			endproperty
			a_pardet: assert property (p_pardet)
				else $error("Parallel detect not half duplex");

			property p_sym;
				neg_full && lb.pause && pb.pause
				|=> rx_en_reg[gp] && tx_en_reg[gp];
			endproperty
			a_sym: assert property (p_sym)
				else $error("Symmetric pause not enabled");

			property p_asym_tx;
				neg_full && !lb.pause && lb.asym_pause && pb.pause &&
				pb.asym_pause |=> tx_en_reg[gp] && !rx_en_reg[gp];
			endproperty
			a_asym_tx: assert property (p_asym_tx)
				else $error("Asymmetric tx case wrong");

			property p_asym_rx;
				neg_full && lb.pause && lb.asym_pause && !pb.pause &&
				pb.asym_pause |=> rx_en_reg[gp] && !tx_en_reg[gp];
			endproperty
			a_asym_rx: assert property (p_asym_rx)
				else $error("Asymmetric rx case wrong");

			property p_none;
				neg_full && !(lb.pause && pb.pause) &&
				!(!lb.pause && lb.asym_pause && pb.pause && pb.asym_pause) &&
				!(lb.pause && lb.asym_pause && !pb.pause && pb.asym_pause)
				|=> !rx_en_reg[gp] && !tx_en_reg[gp];
			endproperty
			a_none: assert property (p_none)
				else $error("Flow control enabled in other case");

			property p_gate;
				backpressure_assert_out[gp] || pause_send_out[gp]
				|-> tx_en_reg[gp];
			endproperty
			a_gate: assert property (p_gate)
				else $error("Flow control action without enable");

			property p_load;
				pause_frame_valid_in[gp] && rx_en_reg[gp]
				|=> cnt_reg[gp] == $past(pause_quanta_in[gp]);
			endproperty
			a_load: assert property (p_load)
				else $error("Pause counter not loaded");

			property p_ignore;
				!rx_en_reg[gp] |=> !tx_xoff_out[gp];
			endproperty
			a_ignore: assert property (p_ignore)
				else $error("Pause held without receive enable");

			c_sym: cover property (neg_full && lb.pause && pb.pause);
			c_asym: cover property (tx_en_reg[gp] && !rx_en_reg[gp] &&
				link_state_in[gp].full_duplex);
			c_xoff: cover property (tx_xoff_out[gp] ##1 !tx_xoff_out[gp]);
		end
	endgenerate

endmodule

//--- testbench/fcr_mac_model.sv
// Purpose: Port MAC stand-in that feeds pause and timing events
// Assumes: All three ports see the same events at the same time
// Notes:   Quanta lines toggle outside the valid pulse

`timescale 1ns/1ps

module fcr_mac_model #(
	parameter int TICK_DIV = 4
) (
	// Clock, reset and bench commands
	input  logic             clk_sys_in,
	input  logic             rst_n_in,
	input  logic             frame_req_in,
	input  logic [15:0]      quanta_in,
	input  logic             tick_en_in,
	input  logic             busy_in,
	input  logic             req_in,
	// Events toward the resolver
	output logic [2:0]       pause_frame_valid_out,
	output logic [2:0][15:0] pause_quanta_out,
	output logic [2:0]       slot_tick_out,
	output logic [2:0]       mac_tx_busy_out,
	output logic [2:0]       bp_request_out,
	output logic [2:0]       pause_request_out
);
	logic [2:0]       valid_reg;
	logic [2:0][15:0] quanta_reg;
	logic [7:0]       div_reg;

	// Frame pulse, slot ticks and levels
	always @(posedge clk_sys_in) begin
		valid_reg  <= frame_req_in ? 3'h7 : 3'h0;
		quanta_reg <= frame_req_in ? {3{quanta_in}} : ~quanta_reg;
		if (!rst_n_in || !tick_en_in || div_reg == 8'(TICK_DIV - 1)) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end
	assign pause_frame_valid_out = valid_reg;
	assign pause_quanta_out      = quanta_reg;
	assign slot_tick_out         = {3{tick_en_in && div_reg == 8'h00}};
	assign mac_tx_busy_out       = {3{busy_in}};
	assign bp_request_out        = {3{req_in}};
	assign pause_request_out     = {3{req_in}};
endmodule

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the flow control enable resolver
// Assumes: All ports get the same settings; port 0 bits go in swapped
// Notes:   Expected enables come from a bench-side priority function

`timescale 1ns/1ps

module tb_top;
	import fcr_pkg::*;

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic             clk_sys_in = 1'b0;
	logic             rst_n_in   = 1'b0;
	fcr_manual_t      man        = 4'h0;
	fcr_link_t [2:0]  link       = 12'h000;
	fcr_pause_adv_t   loc        = 2'h0;
	fcr_pause_adv_t   par        = 2'h0;
	logic             frame_req  = 1'b0;
	logic [15:0]      quanta     = 16'h0000;
	logic             tick_en    = 1'b0;
	logic             busy       = 1'b0;
	logic             req        = 1'b0;
	logic [2:0]       pfv, tick, mbusy, bpr, psr;
	logic [2:0][15:0] pq, cnt;
	logic [2:0]       tx_en, rx_en, bp_out, ps_out, xoff;
	int               err_count  = 0;
	int               tests_run  = 0;
	int               n;

	// Clock
	always #2 clk_sys_in = ~clk_sys_in;

	fcr_mac_model fcr_mac_model_inst (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.frame_req_in(frame_req), .quanta_in(quanta),
		.tick_en_in(tick_en), .busy_in(busy), .req_in(req),
		.pause_frame_valid_out(pfv), .pause_quanta_out(pq),
		.slot_tick_out(tick), .mac_tx_busy_out(mbusy),
		.bp_request_out(bpr), .pause_request_out(psr)
	);

	fcr_flow_ctrl_resolver fcr_flow_ctrl_resolver_inst (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.port0_external_manual_flow_ctrl_in(man),
		.port1_manual_flow_ctrl_in(man), .port2_manual_flow_ctrl_in(man),
		.link_state_in(link),
		.port1_phy_negotiation_advert_in(loc),
		.port1_phy_partner_ability_in(par),
		.port2_phy_negotiation_advert_in(loc),
		.port2_phy_partner_ability_in(par),
		.virtual_phy_negotiation_advert_in(par),
		.virtual_phy_partner_ability_in(loc),
		.pause_frame_valid_in(pfv), .pause_quanta_in(pq),
		.slot_tick_in(tick), .mac_tx_busy_in(mbusy),
		.bp_request_in(bpr), .pause_request_in(psr),
		.tx_flow_ctrl_en_out(tx_en), .rx_flow_ctrl_en_out(rx_en),
		.backpressure_assert_out(bp_out), .pause_send_out(ps_out),
		.tx_xoff_out(xoff), .pause_count_out(cnt)
	);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Expected {rx, tx} from duplex, negotiation and ability bits
	function automatic fcr_fc_en_t exp_en(fcr_manual_t m, fcr_link_t l,
			fcr_pause_adv_t lo, fcr_pause_adv_t pa);
		fcr_fc_en_t e;
		e = 2'h0;
		if (!m.flow_ctrl_override && l.an_enable && !l.an_complete) begin
			e = 2'h0;
		end else if (!l.full_duplex || (!m.flow_ctrl_override &&
				l.an_enable && !l.partner_an_able)) begin
			e.tx_en = m.backpressure_enable;
		end else if (m.flow_ctrl_override || !l.an_enable) begin
			e = {m.manual_rx_pause_enable, m.manual_tx_pause_enable};
		end else if (lo.pause && pa.pause) begin
			e = 2'h3;
		end else if (!lo.pause && lo.asym_pause && pa.pause && pa.asym_pause) begin
			e.tx_en = 1'b1;
		end else if (lo.pause && lo.asym_pause && !pa.pause && pa.asym_pause) begin
			e.rx_en = 1'b1;
		end
		return e;
	endfunction

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask

	// Apply one setting to all ports and compare both enables
	task automatic apply_chk(input fcr_manual_t m, input fcr_link_t l,
			input fcr_pause_adv_t lo, input fcr_pause_adv_t pa);
		fcr_fc_en_t e;
		@(posedge clk_sys_in);
		man  <= m;
		link <= {3{l}};
		loc  <= lo;
		par  <= pa;
		repeat (2) @(posedge clk_sys_in);
		#1;
		e = exp_en(m, l, lo, pa);
		chk(48'(tx_en), 48'({3{e.tx_en}}));
		chk(48'(rx_en), 48'({3{e.rx_en}}));
	endtask

	task automatic send_frame(input logic [15:0] q);
		@(posedge clk_sys_in);
		frame_req <= 1'b1;
		quanta    <= q;
		@(posedge clk_sys_in);
		frame_req <= 1'b0;
		@(posedge clk_sys_in);
		#1;
	endtask

	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish;
	end

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		repeat (7) @(posedge clk_sys_in);
		#1;
		chk(48'({tx_en, rx_en, xoff}), 48'h0);
		@(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			// Port 0 gets the bits swapped at the pins
			apply_chk(4'h0, 4'hf, i[3:2], i[1:0]);
		end
		$display("test negotiated table done");
		apply_chk(4'hd, 4'he, 2'h3, 2'h3);
		apply_chk(4'h4, 4'h0, 2'h3, 2'h3);
		apply_chk(4'ha, 4'hf, 2'h3, 2'h3);
		apply_chk(4'h1, 4'h1, 2'h3, 2'h0);
		apply_chk(4'ha, 4'h9, 2'h3, 2'h3);
		apply_chk(4'h4, 4'h9, 2'h3, 2'h3);
		apply_chk(4'h4, 4'hd, 2'h3, 2'h3);
		$display("test override and duplex done");
		@(posedge clk_sys_in);
		req <= 1'b1;
		apply_chk(4'h4, 4'he, 2'h3, 2'h3);
		chk(48'({bp_out, ps_out}), 48'h38);
		apply_chk(4'h0, 4'hf, 2'h3, 2'h3);
		chk(48'({bp_out, ps_out}), 48'h07);
		$display("test gated requests done");
		// Ticks run while the MAC is busy, so the count must hold
		@(posedge clk_sys_in);
		busy    <= 1'b1;
		tick_en <= 1'b1;
		send_frame(16'h0003);
		chk(48'(xoff), 48'h7);
		chk(48'(cnt), {3{16'h0003}});
		repeat (4) @(posedge clk_sys_in);
		#1;
		chk(48'(cnt), {3{16'h0003}});
		@(posedge clk_sys_in);
		busy <= 1'b0;
		n = 0;
		while (xoff !== 3'h0 && n < 40) begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end
		chk(48'(n >= 8 && n <= 14), 48'h1);
		chk(48'(xoff), 48'h0);
		chk(48'(cnt), 48'h0);
		apply_chk(4'ha, 4'hf, 2'h3, 2'h3);
		send_frame(16'h0005);
		chk(48'(xoff), 48'h0);
		chk(48'(cnt), 48'h0);
		$display("test pause counter done");
		// A loaded counter and both enables must clear in reset
		apply_chk(4'h0, 4'hf, 2'h3, 2'h3);
		send_frame(16'h0005);
		chk(48'(xoff), 48'h7);
		@(posedge clk_sys_in);
		rst_n_in <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		chk(48'({tx_en, rx_en, xoff}), 48'h0);
		chk(48'(cnt), 48'h0);
		$display("test mid-run reset done");
		tally_and_finish;
	end
endmodule
